/* lcdc_cfg.svh */
// Purpose: Constants of the LCD driver command decoder.
// Assumes: Included by the checker and both ends.
// Notes: Command codes are byte values or high-bit prefixes of the byte written with cmd_data_select low.
`ifndef LCDC_CFG_SVH
`define LCDC_CFG_SVH
`define LCDC_CMD_REVERSE 8'hA6
`define LCDC_CMD_ALL_LIT 8'hA4
`define LCDC_CMD_BIAS 8'hA2
`define LCDC_CMD_RMW 8'hE0
`define LCDC_CMD_END 8'hEE
`define LCDC_CMD_SWRESET 8'hE2
`define LCDC_CMD_SCAN 4'hC
`define LCDC_CMD_PAGE 4'hB
`define LCDC_CMD_LINE 2'h1
`define LCDC_CMD_RATIO 5'h04
`define LCDC_CMD_CONTRAST 8'h81
`define LCDC_CMD_POWER 5'h05
`define LCDC_CMD_COL_HI 4'h1
`define LCDC_CMD_COL_LO 4'h0
`define LCDC_CMD_TEST 4'hF
`define LCDC_CONTRAST_RST 6'h20
`define LCDC_COLUMN_MAX 8'hC7
`define LCDC_RESET_CYCLES 4'h4
`endif

/* lcdc_checker.sv */
// Purpose: Checks the command link between the host and the driver.
// Assumes: One clock domain; the flag in read data bit 4 shows resetting.
// Notes: Only the link signals are seen here.
`timescale 1ns/10ps
`include "lcdc_cfg.svh"
module lcdc_checker
    import lcdc_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic resetn, // Reset, active low.
    input wire logic wr_strobe, // Write strobe.
    input wire logic rd_strobe, // Read strobe.
    input wire logic cmd_data_select, // High for display data.
    input wire logic [7:0] data, // Written byte.
    input wire logic hardware_reset_pin_n, // Device reset pin.
    input wire logic [7:0] rd_data // Status byte.
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ---------------------------------------------
    // Sequences
    // ---------------------------------------------
    sequence s_swreset;
        $rose(wr_strobe) && !cmd_data_select && data == `LCDC_CMD_SWRESET;
    endsequence
    sequence s_flag_pulse;
        ##[1:8] rd_data[4] ##[1:12] !rd_data[4];
    endsequence
    // ---------------------------------------------
    // Properties
    // ---------------------------------------------
    property p_strobe_len;
        $rose(wr_strobe) |-> wr_strobe[*4] ##1 !wr_strobe;
    endproperty
    property p_strobe_gap;
        $fell(wr_strobe) |-> !wr_strobe[*4];
    endproperty
    property p_data_hold;
        wr_strobe && $past(wr_strobe) |-> $stable(data) && $stable(cmd_data_select);
    endproperty
    property p_no_read;
        !rd_strobe;
    endproperty
    property p_swreset_flag;
        s_swreset |-> s_flag_pulse;
    endproperty
    property p_flag_len;
        $rose(rd_data[4]) |-> rd_data[4][*4];
    endproperty
    property p_pin_flag;
        $fell(hardware_reset_pin_n) |-> ##[1:4] rd_data[4];
    endproperty
    property p_release_flag;
        $rose(resetn) |-> rd_data[4] ##[1:8] !rd_data[4];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
    a_strobe_gap: assert property (p_strobe_gap) else $error("strobe gap short");
    a_data_hold: assert property (p_data_hold) else $error("byte moved in strobe");
    a_no_read: assert property (p_no_read) else $error("read strobe raised");
    a_swreset_flag: assert property (p_swreset_flag) else $error("no reset pulse");
    a_flag_len: assert property (p_flag_len) else $error("reset flag short");
    a_pin_flag: assert property (p_pin_flag) else $error("pin reset no flag");
    a_release_flag: assert property (p_release_flag) else $error("flag at release");
endmodule

/* lcdc_device.sv */
// Purpose: Command decoder and mode registers of the LCD driver.
// Assumes: Link strobes are produced on sys_clk by the host end.
// Notes: Pin reset, software reset and command decode share one state record.
// Behaviour
// - Low bit selects normal or inverted lighting.
// - Low bit forces every pixel lit.
// - All-lit overrides inverted display.
// - Bias command stores one-bit ratio select.
// - Bias applies only with follower on.
// - RMW saves column, writes only advance.
// - End restores saved column, leaves RMW.
// - Host sends no column set during RMW.
// - Software reset reinitialises listed settings.
// - Software reset keeps display memory.
// - Host must use hardware reset pin.
// - Bit 3 selects common scan order.
// - Low three bits store resistor ratio.
// - After contrast mode only contrast byte.
// - Contrast byte loads low six bits.
// - Contrast load ends contrast mode.
// - Unused contrast is set to middle.
// - Serial bytes arrive MSB first.
// - Status shows resetting during initialisation.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "lcdc_cfg.svh"
module lcdc_device
    import lcdc_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    lcdc_if.device link, // Host link.
    output logic display_inverted, // Pixels drawn inverted.
    output logic all_lit, // Every pixel forced lit.
    output logic bias_sel, // Stored bias select.
    output logic bias_applied, // Bias select in effect.
    output logic scan_reverse, // Common scan from last to first.
    output logic [2:0] resistor_ratio, // Drive voltage resistor ratio.
    output logic [5:0] contrast, // Contrast step.
    output logic [2:0] power_ctrl, // Power control setting.
    output logic [5:0] start_line, // Display start line.
    output logic [3:0] page_addr, // Page address.
    output logic [7:0] column, // Column address.
    output logic rmw_mode, // Read-modify-write active.
    output logic contrast_mode, // Waiting for contrast byte.
    output logic test_mode, // Test mode.
    output logic resetting, // Initialisation in progress.
    output logic pixel_on // Pixel drive for the current memory bit.
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic wr_s1;
        logic wr_s2;
        logic wr_s3;
        logic rd_s1;
        logic rd_s2;
        logic rd_s3;
        logic a0_s1;
        logic a0_s2;
        logic [7:0] d_s1;
        logic [7:0] d_s2;
        logic inv;
        logic lit;
        logic bias;
        logic bias_on;
        logic scan;
        logic [2:0] ratio;
        logic [5:0] contr;
        logic [2:0] power;
        logic [5:0] line;
        logic [3:0] page;
        logic [7:0] col;
        logic [7:0] saved_col;
        logic rmw;
        logic cmode;
        logic test;
        logic [3:0] rst_cnt;
        logic pix;
        logic mem_bit;
        logic rst_flag;
    } lcdc_dev_t;
    lcdc_dev_t q;
    lcdc_dev_t next_q;
    logic wr_ev;
    logic rd_ev;
    logic [7:0] b;

    assign wr_ev = q.wr_s2 & ~q.wr_s3;
    assign rd_ev = q.rd_s2 & ~q.rd_s3;
    assign b = q.d_s2;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.rst_s1 = link.hardware_reset_pin_n;
        next_q.rst_s2 = q.rst_s1;
        next_q.wr_s1 = link.wr_strobe;
        next_q.wr_s2 = q.wr_s1;
        next_q.wr_s3 = q.wr_s2;
        next_q.rd_s1 = link.rd_strobe;
        next_q.rd_s2 = q.rd_s1;
        next_q.rd_s3 = q.rd_s2;
        next_q.a0_s1 = link.cmd_data_select;
        next_q.a0_s2 = q.a0_s1;
        next_q.d_s1 = link.data;
        next_q.d_s2 = q.d_s1;
        if (q.rst_cnt != 4'h0) begin
            next_q.rst_cnt = q.rst_cnt - 4'h1;
        end
        if (wr_ev && q.a0_s2) begin
            next_q.mem_bit = b[0];
            if (q.col != `LCDC_COLUMN_MAX) begin
                next_q.col = q.col + 8'h01;
            end
        end else if (rd_ev && q.a0_s2) begin
            if (!q.rmw && q.col != `LCDC_COLUMN_MAX) begin
                next_q.col = q.col + 8'h01;
            end
        end else if (wr_ev && q.cmode) begin
            next_q.contr = b[5:0];
            next_q.cmode = 1'b0;
        end else if (wr_ev) begin
            next_q.test = 1'b0;
            if ({b[7:1], 1'b0} == `LCDC_CMD_REVERSE) begin
                next_q.inv = b[0];
            end else if ({b[7:1], 1'b0} == `LCDC_CMD_ALL_LIT) begin
                next_q.lit = b[0];
            end else if ({b[7:1], 1'b0} == `LCDC_CMD_BIAS) begin
                next_q.bias = b[0];
            end else if (b == `LCDC_CMD_RMW) begin
                next_q.rmw = 1'b1;
                next_q.saved_col = q.col;
            end else if (b == `LCDC_CMD_END) begin
                if (q.rmw) begin
                    next_q.rmw = 1'b0;
                    next_q.col = q.saved_col;
                end
            end else if (b == `LCDC_CMD_SWRESET) begin
                next_q.line = 6'h00;
                next_q.col = 8'h00;
                next_q.page = 4'h0;
                next_q.scan = 1'b0;
                next_q.ratio = 3'h0;
                next_q.contr = `LCDC_CONTRAST_RST;
                next_q.rmw = 1'b0;
                next_q.rst_cnt = `LCDC_RESET_CYCLES;
            end else if (b[7:4] == `LCDC_CMD_SCAN) begin
                next_q.scan = b[3];
            end else if (b[7:3] == `LCDC_CMD_RATIO) begin
                next_q.ratio = b[2:0];
            end else if (b[7:3] == `LCDC_CMD_POWER) begin
                next_q.power = b[2:0];
            end else if (b == `LCDC_CMD_CONTRAST) begin
                next_q.cmode = 1'b1;
            end else if (b[7:6] == `LCDC_CMD_LINE) begin
                next_q.line = b[5:0];
            end else if (b[7:4] == `LCDC_CMD_PAGE) begin
                next_q.page = b[3:0];
            end else if (b[7:4] == `LCDC_CMD_COL_HI) begin
                next_q.col = {b[3:0], q.col[3:0]};
            end else if (b[7:4] == `LCDC_CMD_COL_LO) begin
                next_q.col = {q.col[7:4], b[3:0]};
            end else if (b[7:4] == `LCDC_CMD_TEST) begin
                next_q.test = 1'b1;
            end
        end
        next_q.bias_on = q.bias & q.power[0];
        next_q.pix = q.lit | (q.mem_bit ^ q.inv);
        // Pin reset wipes the settings but keeps the memory bit, since the
        // pin never touches display memory.
        if (!q.rst_s2) begin
            next_q = '0;
            next_q.rst_s1 = link.hardware_reset_pin_n;
            next_q.rst_s2 = q.rst_s1;
            next_q.contr = `LCDC_CONTRAST_RST;
            next_q.rst_cnt = `LCDC_RESET_CYCLES;
            next_q.mem_bit = q.mem_bit;
        end
        next_q.rst_flag = next_q.rst_cnt != 4'h0;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.contr <= `LCDC_CONTRAST_RST;
            q.rst_cnt <= `LCDC_RESET_CYCLES;
            q.rst_flag <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign link.rd_data = {q.rst_flag, 2'h0, q.rst_flag, 4'h0};
    assign display_inverted = q.inv;
    assign all_lit = q.lit;
    assign bias_sel = q.bias;
    assign bias_applied = q.bias_on;
    assign scan_reverse = q.scan;
    assign resistor_ratio = q.ratio;
    assign contrast = q.contr;
    assign power_ctrl = q.power;
    assign start_line = q.line;
    assign page_addr = q.page;
    assign column = q.col;
    assign rmw_mode = q.rmw;
    assign contrast_mode = q.cmode;
    assign test_mode = q.test;
    assign resetting = q.rst_flag;
    assign pixel_on = q.pix;
endmodule

/* lcdc_driver_command_decoder_bench.sv */
// Purpose: Drives commands through the host end and checks the driver.
// Assumes: Settings settle within four cycles after the host drops busy.
// Notes: Reads are not made, since the host end ties its read strobe.
`timescale 1ns/10ps
module lcd_driver_command_decoder_bench;
    import lcdc_pkg::*;
    logic sys_clk = 0;
    logic resetn = 0;
    logic req = 0;
    logic req_is_data = 0;
    logic [7:0] req_byte = 8'h00;
    logic hw_reset = 0;
    logic busy, inv, lit, bsel, bapp, scan, rmw, cmode, tmode, rsting, pix;
    logic [2:0] ratio, pwr;
    logic [5:0] contrast, sline;
    logic [3:0] page;
    logic [7:0] column, status;
    int bad_count = 0;
    int samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    lcdc_if lcdc_if_i();
    lcdc_device lcdc_device_i(.sys_clk(sys_clk), .resetn(resetn), .link(lcdc_if_i.device),
        .display_inverted(inv), .all_lit(lit), .bias_sel(bsel), .bias_applied(bapp),
        .scan_reverse(scan), .resistor_ratio(ratio), .contrast(contrast), .power_ctrl(pwr),
        .start_line(sline), .page_addr(page), .column(column), .rmw_mode(rmw),
        .contrast_mode(cmode), .test_mode(tmode), .resetting(rsting), .pixel_on(pix));
    lcdc_host lcdc_host_i(.sys_clk(sys_clk), .resetn(resetn), .link(lcdc_if_i.host),
        .req(req), .req_is_data(req_is_data), .req_byte(req_byte), .hw_reset(hw_reset),
        .busy(busy), .status(status));
    lcdc_checker lcdc_checker_i(.sys_clk(sys_clk), .resetn(resetn),
        .wr_strobe(lcdc_if_i.wr_strobe), .rd_strobe(lcdc_if_i.rd_strobe),
        .cmd_data_select(lcdc_if_i.cmd_data_select), .data(lcdc_if_i.data),
        .hardware_reset_pin_n(lcdc_if_i.hardware_reset_pin_n), .rd_data(lcdc_if_i.rd_data));
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task send(input logic d, input logic [7:0] b);
        int n;
        @(posedge sys_clk);
        req <= 1'b1;
        req_is_data <= d;
        req_byte <= b;
        @(posedge sys_clk);
        req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge sys_clk);
        chk("busy", 8'(busy), 8'h00);
        repeat (4) @(posedge sys_clk);
    endtask
    task end_sim;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ---------------------------------------------
    // Tests
    // ---------------------------------------------
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1 chk("contrast_rst", 8'(contrast), 8'h20);
        chk("flag_set", 8'(rsting), 8'h01);
        repeat (8) @(posedge sys_clk);
        chk("flag_clr", 8'(rsting), 8'h00);
        send(1, 8'h01);
        send(0, 8'hA7);
        chk("inv", 8'(inv), 8'h01);
        chk("pix_inv", 8'(pix), 8'h00);
        send(0, 8'hA5);
        chk("lit", 8'(lit), 8'h01);
        chk("pix", 8'(pix), 8'h01);
        send(0, 8'hA4);
        chk("unlit", 8'(lit), 8'h00);
        chk("pix_unlit", 8'(pix), 8'h00);
        send(0, 8'hA6);
        chk("norm", 8'(inv), 8'h00);
        send(0, 8'hA3);
        chk("bias", 8'(bsel), 8'h01);
        chk("bias_off", 8'(bapp), 8'h00);
        send(0, 8'h29);
        chk("bias_on", 8'(bapp), 8'h01);
        chk("power", 8'(pwr), 8'h01);
        send(0, 8'hA2);
        chk("bias_lo", 8'(bsel), 8'h00);
        send(0, 8'hCF);
        chk("scan_rev", 8'(scan), 8'h01);
        send(0, 8'hC7);
        chk("scan_fwd", 8'(scan), 8'h00);
        send(0, 8'h27);
        chk("ratio7", 8'(ratio), 8'h07);
        send(0, 8'h25);
        chk("ratio5", 8'(ratio), 8'h05);
        send(0, 8'h81);
        chk("cmode", 8'(cmode), 8'h01);
        send(0, 8'hE5);
        chk("cval", 8'(contrast), 8'h25);
        chk("cmode_off", 8'(cmode), 8'h00);
        chk("not_rmw", 8'(rmw), 8'h00);
        send(0, 8'h45);
        send(0, 8'hB3);
        send(0, 8'h11);
        send(0, 8'h02);
        chk("col", column, 8'h12);
        send(0, 8'hE0);
        chk("rmw", 8'(rmw), 8'h01);
        send(1, 8'h5B);
        chk("col_inc", column, 8'h13);
        send(0, 8'hEE);
        chk("col_back", column, 8'h12);
        chk("rmw_off", 8'(rmw), 8'h00);
        send(0, 8'hEE);
        chk("col_keep", column, 8'h12);
        send(0, 8'hF0);
        chk("test", 8'(tmode), 8'h01);
        send(0, 8'hE2);
        repeat (8) @(posedge sys_clk);
        chk("sw_col", column, 8'h00);
        chk("sw_line", 8'(sline), 8'h00);
        chk("sw_page", 8'(page), 8'h00);
        chk("sw_ratio", 8'(ratio), 8'h00);
        chk("sw_contrast", 8'(contrast), 8'h20);
        chk("sw_bias", 8'(bsel), 8'h00);
        chk("sw_test", 8'(tmode), 8'h00);
        chk("sw_mem", 8'(pix), 8'h01);
        send(0, 8'h81);
        send(0, 8'h20);
        send(0, 8'hA7);
        @(posedge sys_clk);
        hw_reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("pin_flag", 8'(rsting), 8'h01);
        @(posedge sys_clk);
        hw_reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk("status_flag", status, 8'h90);
        repeat (11) @(posedge sys_clk);
        chk("pin_inv", 8'(inv), 8'h00);
        chk("pin_flag_clr", 8'(rsting), 8'h00);
        chk("status_clr", status, 8'h00);
        end_sim();
    end
endmodule

/* lcdc_host.sv */
// Purpose: Host end that writes command and data bytes to the driver.
// Assumes: User requests are held off while busy is high.
// Notes: Each write keeps the strobe high for several cycles so the
// device synchroniser sees it; the reset pin is driven from user input.
`timescale 1ns/10ps
`include "lcdc_cfg.svh"
module lcdc_host
    import lcdc_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    lcdc_if.host link, // Device link.
    input wire logic req, // Write request pulse.
    input wire logic req_is_data, // High for display data.
    input wire logic [7:0] req_byte, // Byte to write.
    input wire logic hw_reset, // Drive the device reset pin.
    output logic busy, // Write in progress.
    output logic [7:0] status // Last status seen.
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        lcdc_host_st_t st;
        logic [2:0] cnt;
        logic wr;
        logic a0;
        logic [7:0] d;
        logic rst_n;
        logic [7:0] stat;
        logic [7:0] stat_s1;
    } lcdc_host_s_t;
    lcdc_host_s_t q;
    lcdc_host_s_t next_q;

    always_comb begin
        next_q = q;
        next_q.rst_n = ~hw_reset;
        next_q.stat_s1 = link.rd_data;
        next_q.stat = q.stat_s1;
        case (q.st)
            LCDC_IDLE: begin
                if (req) begin
                    next_q.st = LCDC_CMD;
                    next_q.a0 = req_is_data;
                    next_q.d = req_byte;
                    next_q.cnt = 3'h0;
                end
            end
            LCDC_CMD: begin
                next_q.wr = 1'b1;
                next_q.cnt = q.cnt + 3'h1;
                if (q.cnt == 3'h3) begin
                    next_q.st = LCDC_DAT;
                    next_q.cnt = 3'h0;
                end
            end
            LCDC_DAT: begin
                next_q.wr = 1'b0;
                next_q.cnt = q.cnt + 3'h1;
                if (q.cnt == 3'h3) begin
                    next_q.st = LCDC_IDLE;
                end
            end
            default: next_q.st = LCDC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= LCDC_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign link.wr_strobe = q.wr;
    assign link.rd_strobe = 1'b0;
    assign link.cmd_data_select = q.a0;
    assign link.data = q.d;
    assign link.hardware_reset_pin_n = q.rst_n;
    assign busy = q.st != LCDC_IDLE;
    assign status = q.stat;
endmodule

/* lcdc_if.sv */
// Purpose: Parallel write link between host and LCD driver.
// Assumes: One write per write strobe pulse, taken at its rising edge.
// Notes: Serial bytes are treated as arriving already assembled, MSB first.
`timescale 1ns/10ps
interface lcdc_if;
    logic wr_strobe;
    logic rd_strobe;
    logic cmd_data_select;
    logic [7:0] data;
    logic hardware_reset_pin_n;
    logic [7:0] rd_data;
    modport device (input wr_strobe, rd_strobe, cmd_data_select, data,
                    hardware_reset_pin_n, output rd_data);
    modport host (output wr_strobe, rd_strobe, cmd_data_select, data,
                  hardware_reset_pin_n, input rd_data);
endinterface

/* lcdc_pkg.sv */
// Purpose: Types shared by both ends of the command link.
// Assumes: The constants header is present.
// Notes: None.
package lcdc_pkg;
    typedef enum {LCDC_IDLE, LCDC_CMD, LCDC_DAT} lcdc_host_st_t;
endpackage
